// ==== rtl/lane_ratio_regs.svh ====
// constants for byte-lane select, ratio strap and address parity logic
// assumes inclusion by the decode design file only
`ifndef LANE_RATIO_REGS_SVH
`define LANE_RATIO_REGS_SVH
`define LANES 4'd8
`define LANE_WIDTH 8
`define ADDR_HI 31
`define ADDR_PAR_LO 5
`define ADDR_LO 3
`define DATA_WIDTH 64
`define SEL_NONE 8'hff
// strap settles after the two sync stages flush
`define SYNC_STAGES 2
`define SETTLE_BITS 2
`define SETTLE_EDGES 2'h2
`define SETTLE_ONE 2'h1
`define STRAP_PULLED 3'h7
`define RATIO_2P5 3'h4
`define RATIO_3P0 3'h5
`define RATIO_3P5 3'h7
`define RATIO_4P0 3'h2
`define RATIO_4P5 3'h0
`define RATIO_5P0 3'h1
`define RATIO_5P5 3'h3
`define RATIO_6P0 3'h6
// ratio in half steps: 2.5x is 5
`define HALVES_2P5 4'h5
`define HALVES_3P0 4'h6
`define HALVES_3P5 4'h7
`define HALVES_4P0 4'h8
`define HALVES_4P5 4'h9
`define HALVES_5P0 4'ha
`define HALVES_5P5 4'hb
`define HALVES_6P0 4'hc
`endif

// ==== rtl/lane_ratio_pkg.sv ====
// types shared by the lane and ratio decode block
// assumes lane_ratio_regs.svh alongside
package lane_ratio_pkg;
  typedef enum logic [1:0]
  {
    CYC_IDLE = 2'h0,
    CYC_READ = 2'h1,
    CYC_WRITE = 2'h3,
    CYC_SPECIAL = 2'h2
  } cyc_kind_t;
  typedef logic [3:0] ratio_halves_t;
endpackage : lane_ratio_pkg

// ==== rtl/pin_sync.sv ====
// two-stage synchroniser for a group of pin inputs
// assumes a single clock and synchronous active-low reset
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      meta <= INIT;
      q_o <= INIT;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : pin_sync

// ==== rtl/lane_ratio_decode.sv ====
// byte-lane select driver, ratio strap decode and address parity
// assumes bus-clock clk_i; strap and address pins are asynchronous
`timescale 1ns/10ps
`include "lane_ratio_regs.svh"
module lane_ratio_decode (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire lane_ratio_pkg::cyc_kind_t cyc_kind_i,
  input wire logic cyc_start_i,
  input wire logic [7:0] lane_mask_i,
  input wire logic [7:0] special_code_i,
  input wire logic [`ADDR_HI:3] addr_out_i,
  input wire logic [2:0] core_ratio_strap_i,
  input wire logic strap_driven_i,
  input wire logic [`ADDR_HI:3] addr_pin_i,
  input wire logic addr_parity_bit_i,
  input wire logic addr_sample_i,
  output logic [7:0] byte_lane_sel_n_o,
  output logic addr_parity_bit_o,
  output lane_ratio_pkg::ratio_halves_t ratio_halves_o,
  output logic ratio_valid_o,
  output logic addr_parity_err_n_o
);
  import lane_ratio_pkg::*;

  logic [2:0] strap_pin;
  logic [2:0] strap_sync;
  logic [`ADDR_HI:3] addr_sync;
  logic par_sync;
  logic sample_sync;
  logic [7:0] next_sel_n;
  ratio_halves_t next_halves;
  logic par_fail;
  logic [`SETTLE_BITS-1:0] settle;
  logic settle_done;
  logic addr_ones;

  // -------------------------------------------------------------
  // elaboration checks on the shared constants
  // -------------------------------------------------------------
  // parity field must lie inside the driven address
  if (`ADDR_PAR_LO > `ADDR_HI || `ADDR_PAR_LO < `ADDR_LO)
  begin : g_bad_par_field
    $error("parity field outside address bus");
  end
  // eight selects of one byte each span the data bus
  if (`LANES * `LANE_WIDTH != `DATA_WIDTH)
  begin : g_bad_lanes
    $error("byte lanes do not span the data bus");
  end
  // a floating strap must decode to the default ratio
  if (`STRAP_PULLED != `RATIO_3P5)
  begin : g_bad_pull
    $error("pulled strap does not select default ratio");
  end
  // the strap must not be taken before the syncs flush
  if (`SETTLE_EDGES < `SYNC_STAGES)
  begin : g_bad_settle
    $error("strap latched before synchronisers flush");
  end
  // half-step ratios must fit the ratio output
  if ($bits(ratio_halves_t) != $bits(`HALVES_6P0))
  begin : g_bad_halves
    $error("half-step ratio width mismatch");
  end

  // -------------------------------------------------------------
  // strap pullups and pin synchronisers
  // -------------------------------------------------------------
  // undriven strap reads as all ones
  assign strap_pin = strap_driven_i ? core_ratio_strap_i
                                    : `STRAP_PULLED;

  pin_sync #(.WIDTH(3), .INIT(`STRAP_PULLED)) u_strap_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(strap_pin),
    .q_o(strap_sync)
  );

  pin_sync #(.WIDTH(`ADDR_HI - `ADDR_LO + 1)) u_addr_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(addr_pin_i),
    .q_o(addr_sync)
  );

  pin_sync #(.WIDTH(1)) u_par_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(addr_parity_bit_i),
    .q_o(par_sync)
  );

  pin_sync #(.WIDTH(1)) u_sample_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(addr_sample_i),
    .q_o(sample_sync)
  );

  // -------------------------------------------------------------
  // byte-lane selects
  // -------------------------------------------------------------
  always_comb
  begin
    next_sel_n = byte_lane_sel_n_o;
    if (cyc_start_i)
    begin
      case (cyc_kind_i)
        CYC_READ, CYC_WRITE:
        begin
          // active-high mask inverts onto the low-true selects
          next_sel_n = ~lane_mask_i;
        end
        CYC_SPECIAL:
        begin
          // special cycles pass their code through raw
          next_sel_n = special_code_i;
        end
        CYC_IDLE:
        begin
          next_sel_n = `SEL_NONE;
        end
        default:
        begin
          next_sel_n = `SEL_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      byte_lane_sel_n_o <= `SEL_NONE;
    else
      byte_lane_sel_n_o <= next_sel_n;
  end

  // -------------------------------------------------------------
  // driven address parity
  // -------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      addr_parity_bit_o <= 1'b0;
    else if (cyc_start_i)
      addr_parity_bit_o <= ^addr_out_i[`ADDR_HI:`ADDR_PAR_LO];
  end

  // -------------------------------------------------------------
  // ratio decode
  // -------------------------------------------------------------
  always_comb
  begin
    case (strap_sync)
      `RATIO_2P5: next_halves = `HALVES_2P5;
      `RATIO_3P0: next_halves = `HALVES_3P0;
      `RATIO_3P5: next_halves = `HALVES_3P5;
      `RATIO_4P0: next_halves = `HALVES_4P0;
      `RATIO_4P5: next_halves = `HALVES_4P5;
      `RATIO_5P0: next_halves = `HALVES_5P0;
      `RATIO_5P5: next_halves = `HALVES_5P5;
      `RATIO_6P0: next_halves = `HALVES_6P0;
      default: next_halves = `HALVES_3P5;
    endcase
  end

  // edges since reset release, stops once the syncs have flushed
  assign settle_done = (settle == `SETTLE_EDGES);

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      settle <= '0;
    else if (!settle_done)
      settle <= settle + `SETTLE_ONE;
  end

  // ratio caught once, from the flushed strap sync
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      ratio_halves_o <= `HALVES_3P5;
    else if (settle_done && !ratio_valid_o)
      ratio_halves_o <= next_halves;
  end

  // later strap changes are ignored until the next reset
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      ratio_valid_o <= 1'b0;
    else if (settle_done)
      ratio_valid_o <= 1'b1;
  end

  // -------------------------------------------------------------
  // sampled address parity check
  // -------------------------------------------------------------
  // odd ones count over parity bit and line address is a fail
  assign addr_ones = ^{par_sync, addr_sync[`ADDR_HI:`ADDR_PAR_LO]};
  assign par_fail = sample_sync & addr_ones;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      addr_parity_err_n_o <= 1'b1;
    else
      addr_parity_err_n_o <= ~par_fail;
  end
endmodule : lane_ratio_decode

// ==== verif/lane_ratio_decode_sva.sv ====
// checker for lane, ratio and parity outputs
// assumes binding to the decode block
`timescale 1ns/10ps
module lane_ratio_sva (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire lane_ratio_pkg::cyc_kind_t cyc_kind_i,
  input wire logic cyc_start_i,
  input wire logic [7:0] lane_mask_i,
  input wire logic [7:0] special_code_i,
  input wire logic [31:3] addr_out_i,
  input wire logic [31:3] addr_pin_i,
  input wire logic addr_parity_bit_i,
  input wire logic addr_sample_i,
  input wire logic [7:0] byte_lane_sel_n_o,
  input wire logic addr_parity_bit_o,
  input wire lane_ratio_pkg::ratio_halves_t ratio_halves_o,
  input wire logic ratio_valid_o,
  input wire logic addr_parity_err_n_o
);
  import lane_ratio_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence bad_sample;
    addr_sample_i && ^{addr_parity_bit_i, addr_pin_i[31:5]};
  endsequence
  a_rw_lanes: assert property (
    cyc_start_i && cyc_kind_i inside {CYC_READ, CYC_WRITE}
    |=> byte_lane_sel_n_o == ~$past(lane_mask_i)) else $error("lanes");
  a_special_code: assert property (
    cyc_start_i && cyc_kind_i == CYC_SPECIAL
    |=> byte_lane_sel_n_o == $past(special_code_i)) else $error("special");
  a_idle_lanes: assert property (
    cyc_start_i && cyc_kind_i == CYC_IDLE
    |=> byte_lane_sel_n_o == 8'hff) else $error("idle");
  a_lanes_hold: assert property (
    !cyc_start_i |=> $stable(byte_lane_sel_n_o)) else $error("hold");
  a_parity_gen: assert property (
    cyc_start_i |=> addr_parity_bit_o == ^$past(addr_out_i[31:5]))
    else $error("parity bit");
  a_ratio_range: assert property (
    ratio_valid_o |-> ratio_halves_o inside {[4'h5:4'hc]}) else $error("ratio");
  a_ratio_hold: assert property (
    ratio_valid_o |=> ratio_valid_o && $stable(ratio_halves_o))
    else $error("ratio moved");
  a_err_pulse: assert property (
    bad_sample |-> ##3 !addr_parity_err_n_o) else $error("no error");
  a_err_cause: assert property (
    $fell(addr_parity_err_n_o) |-> $past(addr_sample_i, 3)) else $error("err");
endmodule : lane_ratio_sva
bind lane_ratio_decode lane_ratio_sva u_lane_ratio_sva (.clk_i, .rstn_i,
  .cyc_kind_i, .cyc_start_i, .lane_mask_i, .special_code_i, .addr_out_i,
  .addr_pin_i, .addr_parity_bit_i, .addr_sample_i, .byte_lane_sel_n_o,
  .addr_parity_bit_o, .ratio_halves_o, .ratio_valid_o, .addr_parity_err_n_o);

// ==== verif/chipset_model.sv ====
// chipset side: drives sampled address, parity bit and strobe
// assumes the bench calls send just after a rising clock edge
`timescale 1ns/10ps
module chipset_model (
  input wire logic clk_i,
  output logic [31:3] addr_o = 29'h0,
  output logic ap_o = 1'b0,
  output logic sample_o = 1'b0
);
  task send(input logic [31:3] a, input logic bad);
    @(posedge clk_i) #1;
    addr_o = a;
    ap_o = ^a[31:5] ^ bad;
    sample_o = 1'b1;
    @(posedge clk_i) #1;
    sample_o = 1'b0;
    addr_o = ~a;
    ap_o = ~ap_o;
  endtask : send
endmodule : chipset_model

// ==== verif/lane_ratio_decode_tb_top.sv ====
// self-checking bench for the lane and ratio decode block
// assumes the chipset model and the bound checker alongside
`timescale 1ns/10ps
module lane_ratio_decode_tb_top;
  import lane_ratio_pkg::*;
  logic clk_i = 0, rstn_i = 0, cyc_start_i = 0, drv = 1, ap, smp, vld, pb, err_n;
  cyc_kind_t kind = CYC_IDLE;
  logic [7:0] mask = 8'h00, sel;
  logic [31:3] ao = 29'h0, pin;
  logic [2:0] strap = 3'h0;
  ratio_halves_t hal;
  logic [3:0] hv [8] = '{4'h9, 4'ha, 4'h8, 4'hb, 4'h5, 4'h6, 4'hc, 4'h7};
  int n_errors = 0, n_checks = 0;
  initial forever #4 clk_i = ~clk_i;
  lane_ratio_decode u_lane_ratio_decode (.clk_i, .rstn_i, .cyc_kind_i(kind),
    .cyc_start_i, .lane_mask_i(mask), .special_code_i(mask), .addr_out_i(ao),
    .core_ratio_strap_i(strap), .strap_driven_i(drv), .addr_pin_i(pin),
    .addr_parity_bit_i(ap), .addr_sample_i(smp), .byte_lane_sel_n_o(sel),
    .addr_parity_bit_o(pb), .ratio_halves_o(hal), .ratio_valid_o(vld),
    .addr_parity_err_n_o(err_n));
  chipset_model u_chipset_model (.clk_i, .addr_o(pin), .ap_o(ap), .sample_o(smp));
  task conclude;
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  task chk(input logic ok);
    n_checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("ERROR %0t wrong output", $time);
    end
  endtask : chk
  task boot(input logic [2:0] s, input logic d, input logic [3:0] h);
    int i;
    rstn_i = 1'b0;
    strap = s;
    drv = d;
    repeat (8) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    for (i = 0; i < 9 && vld !== 1'b1; i++) @(posedge clk_i) #1;
    chk(i < 9);
    if (i == 9) conclude();
    chk(hal === h);
  endtask : boot
  task cyc(input cyc_kind_t k, input logic [7:0] m, input logic [7:0] e);
    kind = k;
    cyc_start_i = 1'b1;
    mask = m;
    ao = {m, m, m, 5'h15};
    @(posedge clk_i) #1;
    chk(sel === e);
    chk(pb === ^m);
  endtask : cyc
  task t_par(input logic bad);
    int i, c;
    c = 0;
    u_chipset_model.send(29'h0abcdef1, bad);
    for (i = 0; i < 6; i++)
    begin
      @(posedge clk_i) #1;
      c += (err_n === 1'b0);
    end
    chk(c == int'(bad));
  endtask : t_par
  initial
  begin
    for (int s = 0; s < 8; s++) boot(3'(s), 1'b1, hv[s]);
    boot(3'h0, 1'b0, 4'h7);
    cyc(CYC_WRITE, 8'h0f, 8'hf0);
    cyc(CYC_READ, 8'h81, 8'h7e);
    cyc(CYC_SPECIAL, 8'hfb, 8'hfb);
    cyc(CYC_SPECIAL, 8'h7f, 8'h7f);
    cyc(CYC_READ, 8'h80, 8'h7f);
    cyc_start_i = 1'b0;
    repeat (2) @(posedge clk_i) #1;
    chk(sel === 8'h7f);
    cyc(CYC_IDLE, 8'h00, 8'hff);
    cyc_start_i = 1'b0;
    t_par(1'b0);
    t_par(1'b1);
    conclude();
  end
endmodule : lane_ratio_decode_tb_top
